// ### hdl/port_override_map.svh
`ifndef PORT_OVERRIDE_MAP_SVH
`define PORT_OVERRIDE_MAP_SVH

`define ADDR_PORT_C_DIRECTION   8'h14
`define ADDR_PORT_C_OUTPUT_DATA 8'h15
`define ADDR_PORT_B_PIN_LEVELS  8'h16
`define ADDR_PORT_B_DIRECTION   8'h17
`define ADDR_PORT_B_OUTPUT_DATA 8'h18
`define ADDR_PORT_A_PIN_LEVELS  8'h19
`define ADDR_PORT_A_DIRECTION   8'h1A
`define ADDR_PIN_CONTROL        8'h1B
`define ADDR_PORT_F_DIRECTION   8'h1C
`define ADDR_PORT_F_OUTPUT_DATA 8'h1D
`define ADDR_PORT_G_DIRECTION   8'h1E
`define ADDR_PORT_G_OUTPUT_DATA 8'h1F

`define CTRL_TEST_EN_BIT  0
`define CTRL_ASYNC_BIT    1
`define CTRL_XMEM_BIT     2
`define STAT_LEGACY_BIT   3
`define STAT_SHIFT_BIT    4

`define PF_TDI 7
`define PF_TDO 6
`define PF_TMS 5
`define PF_TCK 4

`define RST_PORT      8'h00
`define RST_PORT_G    5'h00
`define RST_CTRL      3'h1
`define RST_PF_PULLUP 8'hB0
`define RST_PF_IN_EN  8'h0F
`define RST_PG_IN_EN  5'h1F

`endif

// ### hdl/port_override_pkg.sv
package port_override_pkg;

  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DATA_STATE = 16'h0010,
    TAP_EX1_DR   = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EX2_DR   = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_INSTR_STATE = 16'h0800,
    TAP_EX1_IR   = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EX2_IR   = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } tap_state_t;

endpackage

// ### hdl/pin_override_if.sv
`timescale 1ns/1ps
interface pin_override_if #(parameter int W = 8);
  logic [W-1:0] pullup_override_en;
  logic [W-1:0] pullup_override_val;
  logic [W-1:0] direction_override_en;
  logic [W-1:0] direction_override_val;
  logic [W-1:0] out_value_override_en;
  logic [W-1:0] out_value_override_val;
  logic [W-1:0] input_gate_override_en;
  logic [W-1:0] input_gate_override_val;

  modport drive (
    output pullup_override_en, pullup_override_val,
    output direction_override_en, direction_override_val,
    output out_value_override_en, out_value_override_val,
    output input_gate_override_en, input_gate_override_val
  );
  modport apply (
    input pullup_override_en, pullup_override_val,
    input direction_override_en, direction_override_val,
    input out_value_override_en, out_value_override_val,
    input input_gate_override_en, input_gate_override_val
  );
endinterface

// ### hdl/pin_override_mux.sv
`timescale 1ns/1ps
module pin_override_mux #(
  parameter int W = 8
) (
  // override bundle
  pin_override_if.apply  ovr,
  // register-derived control
  input  wire logic [W-1:0] reg_dir,
  input  wire logic [W-1:0] reg_out,
  // resolved pin control
  output logic [W-1:0] dir,
  output logic [W-1:0] out,
  output logic [W-1:0] pullup_on,
  output logic [W-1:0] in_en
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    // pull-up follows its override, else only on an input written high
    always_comb begin
      pullup_on[i] = ovr.pullup_override_en[i] ?
                     ovr.pullup_override_val[i] :
                     (~reg_dir[i] & reg_out[i]);
      dir[i]    = ovr.direction_override_en[i] ?
                  ovr.direction_override_val[i] : reg_dir[i];
      out[i]    = ovr.out_value_override_en[i] ?
                  ovr.out_value_override_val[i] : reg_out[i];
      in_en[i]  = ovr.input_gate_override_en[i] ?
                  ovr.input_gate_override_val[i] : 1'b1;
    end
  end
endmodule // pin_override_mux

// ### hdl/tap_tracker.sv
`timescale 1ns/1ps
module tap_tracker
  import port_override_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic ce,
  // test pins
  input  wire logic enable,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic data_src,
  // state
  output logic      shift_instr_state,
  output logic      shift_data_state,
  output logic      tdo
);
  tap_state_t state;
  tap_state_t next_state;
  logic       tck_prev;
  logic       next_tck_prev;
  logic       next_tdo;
  logic       rise;
  logic       fall;

  assign rise = tck & ~tck_prev;
  assign fall = ~tck & tck_prev;

  always_comb begin
    next_tck_prev = tck;
    next_tdo      = fall ? data_src : tdo;
    next_state    = state;
    if (!enable) begin
      next_state = TAP_RESET;
    end else if (rise) begin
      case (state)
        TAP_RESET:    next_state = tms ? TAP_RESET  : TAP_IDLE;
        TAP_IDLE:     next_state = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   next_state = tms ? TAP_EX1_DR : TAP_SHIFT_DATA_STATE;
        TAP_SHIFT_DATA_STATE: next_state = tms ? TAP_EX1_DR : TAP_SHIFT_DATA_STATE;
        TAP_EX1_DR:   next_state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: next_state = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
        TAP_EX2_DR:   next_state = tms ? TAP_UPD_DR : TAP_SHIFT_DATA_STATE;
        TAP_UPD_DR:   next_state = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   next_state = tms ? TAP_RESET  : TAP_CAP_IR;
        TAP_CAP_IR:   next_state = tms ? TAP_EX1_IR : TAP_SHIFT_INSTR_STATE;
        TAP_SHIFT_INSTR_STATE: next_state = tms ? TAP_EX1_IR : TAP_SHIFT_INSTR_STATE;
        TAP_EX1_IR:   next_state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: next_state = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
        TAP_EX2_IR:   next_state = tms ? TAP_UPD_IR : TAP_SHIFT_INSTR_STATE;
        TAP_UPD_IR:   next_state = tms ? TAP_SEL_DR : TAP_IDLE;
        default:      next_state = TAP_RESET;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= TAP_RESET;
      tck_prev <= 1'b0;
      tdo      <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      tck_prev <= next_tck_prev;
      tdo      <= next_tdo;
    end
  end

  assign shift_instr_state = (state == TAP_SHIFT_INSTR_STATE);
  assign shift_data_state  = (state == TAP_SHIFT_DATA_STATE);

  chk_tdo_on_fall: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ce && !fall) |=> $stable(tdo))
    else $error("test data changed without a falling test clock");
  chk_tap_escape: assert property (
    @(posedge clock) disable iff (sys_rst)
    (ce && enable && rise && tms && state == TAP_SEL_IR)
    |=> state == TAP_RESET)
    else $error("tap did not return to reset");
endmodule // tap_tracker

// ### hdl/port_alt_function_override.sv
`timescale 1ns/1ps
`include "port_override_map.svh"
module port_alt_function_override
  import port_override_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // ports a to c
  input  wire logic [7:0] pa_pin,
  output logic      [7:0] pa_dir,
  input  wire logic [7:0] pb_pin,
  output logic      [7:0] pb_dir,
  output logic      [7:0] pb_out,
  output logic      [7:0] pc_dir,
  output logic      [7:0] pc_out,
  // port f
  input  wire logic [7:0] pf_pin,
  output logic      [7:0] pf_out,
  output logic      [7:0] pf_oe,
  output logic      [7:0] pf_pullup,
  output logic      [7:0] pf_in_en,
  // port g
  output logic      [4:0] pg_out,
  output logic      [4:0] pg_oe,
  output logic      [4:0] pg_pullup,
  output logic      [4:0] pg_in_en,
  // alternate sources
  input  wire logic       test_data_src,
  input  wire logic       xmem_ale,
  input  wire logic       xmem_rd,
  input  wire logic       xmem_wr,
  input  wire logic       legacy_mode
);

  ////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] pa_level;
  logic [7:0] pb_level;
  logic [7:0] pf_dir;
  logic [7:0] pf_data;
  logic [4:0] pg_dir;
  logic [4:0] pg_data;
  logic       test_port_enable;
  logic       async_timer_clock_select;
  logic       ext_memory_enable;
  logic       legacy;
  logic [7:0] next_pa_dir;
  logic [7:0] next_pb_dir;
  logic [7:0] next_pb_out;
  logic [7:0] next_pc_dir;
  logic [7:0] next_pc_out;
  logic [7:0] next_pf_dir;
  logic [7:0] next_pf_data;
  logic [4:0] next_pg_dir;
  logic [4:0] next_pg_data;
  logic [2:0] next_ctrl;
  logic [7:0] next_rdata;
  logic       shift_instr_state;
  logic       shift_data_state;
  logic       tdo;
  logic       in_shift;

  assign in_shift = shift_instr_state | shift_data_state;

  always_comb begin
    next_pa_dir  = pa_dir;
    next_pb_dir  = pb_dir;
    next_pb_out  = pb_out;
    next_pc_dir  = pc_dir;
    next_pc_out  = pc_out;
    next_pf_dir  = pf_dir;
    next_pf_data = pf_data;
    next_pg_dir  = pg_dir;
    next_pg_data = pg_data;
    next_ctrl    = {ext_memory_enable, async_timer_clock_select,
                    test_port_enable};
    if (wr) begin
      case (addr)
        `ADDR_PORT_A_DIRECTION:   next_pa_dir  = wdata;
        `ADDR_PORT_B_DIRECTION:   next_pb_dir  = wdata;
        `ADDR_PORT_C_DIRECTION:   next_pc_dir  = wdata;
        `ADDR_PORT_B_OUTPUT_DATA: next_pb_out  = wdata;
        `ADDR_PORT_C_OUTPUT_DATA: next_pc_out  = wdata;
        `ADDR_PORT_F_DIRECTION:   next_pf_dir  = wdata;
        `ADDR_PORT_F_OUTPUT_DATA: next_pf_data = wdata;
        `ADDR_PIN_CONTROL:        next_ctrl    = wdata[2:0];
        // port g registers ignore writes in legacy mode but still read back
        `ADDR_PORT_G_DIRECTION: begin
          if (!legacy) next_pg_dir = wdata[4:0];
        end
        `ADDR_PORT_G_OUTPUT_DATA: begin
          if (!legacy) next_pg_data = wdata[4:0];
        end
        default: next_ctrl = next_ctrl;
      endcase
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADDR_PORT_A_DIRECTION:   next_rdata = pa_dir;
        `ADDR_PORT_B_DIRECTION:   next_rdata = pb_dir;
        `ADDR_PORT_C_DIRECTION:   next_rdata = pc_dir;
        `ADDR_PORT_B_OUTPUT_DATA: next_rdata = pb_out;
        `ADDR_PORT_C_OUTPUT_DATA: next_rdata = pc_out;
        `ADDR_PORT_A_PIN_LEVELS:  next_rdata = pa_level;
        `ADDR_PORT_B_PIN_LEVELS:  next_rdata = pb_level;
        `ADDR_PORT_F_DIRECTION:   next_rdata = pf_dir;
        `ADDR_PORT_F_OUTPUT_DATA: next_rdata = pf_data;
        `ADDR_PORT_G_DIRECTION:   next_rdata = {3'h0, pg_dir};
        `ADDR_PORT_G_OUTPUT_DATA: next_rdata = {3'h0, pg_data};
        `ADDR_PIN_CONTROL: begin
          next_rdata[`CTRL_TEST_EN_BIT] = test_port_enable;
          next_rdata[`CTRL_ASYNC_BIT]   = async_timer_clock_select;
          next_rdata[`CTRL_XMEM_BIT]    = ext_memory_enable;
          next_rdata[`STAT_LEGACY_BIT]  = legacy;
          next_rdata[`STAT_SHIFT_BIT]   = in_shift;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pa_dir   <= `RST_PORT;
      pb_dir   <= `RST_PORT;
      pb_out   <= `RST_PORT;
      pc_dir   <= `RST_PORT;
      pc_out   <= `RST_PORT;
      pf_dir   <= `RST_PORT;
      pf_data  <= `RST_PORT;
      pg_dir   <= `RST_PORT_G;
      pg_data  <= `RST_PORT_G;
      pa_level <= `RST_PORT;
      pb_level <= `RST_PORT;
      rdata    <= 8'h00;
      legacy   <= 1'b0;
      {ext_memory_enable, async_timer_clock_select,
       test_port_enable} <= `RST_CTRL;
    end else if (ce) begin
      pa_dir   <= next_pa_dir;
      pb_dir   <= next_pb_dir;
      pb_out   <= next_pb_out;
      pc_dir   <= next_pc_dir;
      pc_out   <= next_pc_out;
      pf_dir   <= next_pf_dir;
      pf_data  <= next_pf_data;
      pg_dir   <= next_pg_dir;
      pg_data  <= next_pg_data;
      pa_level <= pa_pin;
      pb_level <= pb_pin;
      rdata    <= next_rdata;
      legacy   <= legacy_mode;
      {ext_memory_enable, async_timer_clock_select,
       test_port_enable} <= next_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // test access port

  // pin levels feed the tap directly; the digital gate only hides them
  // from software, not from the test logic
  tap_tracker u_tap (
    .clock             (clock),
    .sys_rst           (sys_rst),
    .ce                (ce),
    .enable            (test_port_enable),
    .tck               (pf_pin[`PF_TCK]),
    .tms               (pf_pin[`PF_TMS]),
    .data_src          (test_data_src),
    .shift_instr_state (shift_instr_state),
    .shift_data_state  (shift_data_state),
    .tdo               (tdo)
  );

  ////////////////////////////////////////////////////////////////////
  // override generation

  pin_override_if #(.W(8)) f_ovr ();
  pin_override_if #(.W(5)) g_ovr ();

  logic t;
  logic a;
  logic s;
  assign t = test_port_enable;
  assign a = async_timer_clock_select;
  assign s = ext_memory_enable;

  always_comb begin
    f_ovr.pullup_override_en     = {{4{t}}, 4'h0};
    f_ovr.pullup_override_val    = 8'hB0;
    f_ovr.direction_override_en  = {{4{t}}, 4'h0};
    f_ovr.direction_override_val = {1'b0, in_shift, 6'h00};
    f_ovr.out_value_override_en  = {1'b0, t, 6'h00};
    f_ovr.out_value_override_val = {1'b0, tdo, 6'h00};
    f_ovr.input_gate_override_en = {{4{t}}, 4'h0};
    f_ovr.input_gate_override_val = 8'h00;
  end

  always_comb begin
    g_ovr.pullup_override_en     = {a, a, s, s, s};
    g_ovr.pullup_override_val    = 5'h00;
    g_ovr.direction_override_en  = {a, a, s, s, s};
    g_ovr.direction_override_val = 5'h07;
    g_ovr.out_value_override_en  = {2'h0, s, s, s};
    g_ovr.out_value_override_val = {2'h0, xmem_ale, xmem_rd, xmem_wr};
    g_ovr.input_gate_override_en = {a, a, 3'h0};
    g_ovr.input_gate_override_val = 5'h00;
  end

  logic [7:0] f_dir;
  logic [7:0] f_out;
  logic [7:0] f_pu;
  logic [7:0] f_ie;
  logic [4:0] g_dir;
  logic [4:0] g_out;
  logic [4:0] g_pu;
  logic [4:0] g_ie;
  logic [4:0] g_reg_dir;
  logic [4:0] g_reg_out;

  // legacy mode hides the general port, leaving only the alternates
  assign g_reg_dir = legacy ? 5'h00 : pg_dir;
  assign g_reg_out = legacy ? 5'h00 : pg_data;

  pin_override_mux #(.W(8)) u_f_mux (
    .ovr     (f_ovr),
    .reg_dir (pf_dir),
    .reg_out (pf_data),
    .dir     (f_dir),
    .out     (f_out),
    .pullup_on (f_pu),
    .in_en   (f_ie)
  );

  pin_override_mux #(.W(5)) u_g_mux (
    .ovr     (g_ovr),
    .reg_dir (g_reg_dir),
    .reg_out (g_reg_out),
    .dir     (g_dir),
    .out     (g_out),
    .pullup_on (g_pu),
    .in_en   (g_ie)
  );

  // resolved controls are registered so every pin output is a flop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pf_out    <= `RST_PORT;
      pf_oe     <= `RST_PORT;
      pf_pullup <= `RST_PF_PULLUP;
      pf_in_en  <= `RST_PF_IN_EN;
      pg_out    <= `RST_PORT_G;
      pg_oe     <= `RST_PORT_G;
      pg_pullup <= `RST_PORT_G;
      pg_in_en  <= `RST_PG_IN_EN;
    end else if (ce) begin
      pf_out    <= f_out;
      pf_oe     <= f_dir;
      pf_pullup <= f_pu;
      pf_in_en  <= f_ie;
      pg_out    <= g_out;
      pg_oe     <= g_dir;
      pg_pullup <= g_pu;
      pg_in_en  <= g_ie;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  chk_tms_pin_taken: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && t) |=> !pf_oe[5] && !pf_in_en[5])
    else $error("mode select pin still general i/o");
  chk_tck_pin_taken: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && t) |=> !pf_oe[4] && !pf_in_en[4])
    else $error("test clock pin still general i/o");
  chk_test_inputs_forced: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && t)
    |=> pf_pullup[7] && pf_pullup[5] && pf_pullup[4] && !pf_oe[7])
    else $error("test input pins not forced");
  chk_tdo_drive_window: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && t)
    |=> pf_oe[6] == $past(in_shift) && !pf_pullup[6]
        && pf_out[6] == $past(tdo))
    else $error("test data pin drive wrong");
  chk_tdo_tristate: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && t && !in_shift) |=> !pf_oe[6])
    else $error("test data pin driven outside shift");
  chk_analog_untouched: assert property (@(posedge clock)
    disable iff (sys_rst) ce
    |=> pf_oe[3:0] == $past(pf_dir[3:0]) && pf_in_en[3:0] == 4'hF)
    else $error("analog pins overridden");
  chk_legacy_port_g: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && legacy && !s && !a)
    |=> pg_oe == 5'h00 && pg_out == 5'h00)
    else $error("port g general i/o in legacy mode");
  chk_osc_pins_detach: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && a)
    |=> pg_oe[4:3] == 2'h0 && pg_pullup[4:3] == 2'h0
        && pg_in_en[4:3] == 2'h0)
    else $error("oscillator pins not detached");
  chk_strobes_driven: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && s)
    |=> pg_oe[2:0] == 3'h7 && pg_pullup[2:0] == 3'h0
        && pg_out[2:0] == $past({xmem_ale, xmem_rd, xmem_wr}))
    else $error("memory strobes not driven");
  chk_normal_control: assert property (@(posedge clock)
    disable iff (sys_rst) (ce && !a && !s && !legacy)
    |=> pg_oe == $past(pg_dir) && pg_out == $past(pg_data))
    else $error("register control not applied");
  chk_dir_readback: assert property (@(posedge clock)
    disable iff (sys_rst)
    (ce && wr && addr == `ADDR_PORT_A_DIRECTION)
    ##1 (ce && rd && addr == `ADDR_PORT_A_DIRECTION)
    |=> rdata == $past(wdata, 2))
    else $error("direction readback mismatch");
  chk_pin_level_read: assert property (@(posedge clock)
    disable iff (sys_rst)
    (ce && rd && addr == `ADDR_PORT_B_PIN_LEVELS) |=> rdata == $past(pb_level))
    else $error("pin level read mismatch");
  chk_reset_pullups: assert property (@(posedge clock)
    sys_rst |=> pf_pullup[7] && pf_pullup[5] && pf_pullup[4])
    else $error("test pull-ups dropped in reset");

  cov_shift_data: cover property (@(posedge clock) shift_data_state);
  cov_shift_instr: cover property (@(posedge clock) shift_instr_state);
  cov_strobes: cover property (@(posedge clock) s && xmem_wr);
  cov_osc_mode: cover property (@(posedge clock) a && legacy);

endmodule // port_alt_function_override

// ### tb/test_probe.sv
`timescale 1ns/1ps
module test_probe (
  // clock
  input  wire logic clock,
  // probe pins
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock period, halves well over 3 clocks
  task automatic step(input logic m);
    @(posedge clock);
    tms <= m;
    tck <= 1'b0;
    repeat (4) @(posedge clock);
    tck <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
endmodule // test_probe

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "port_override_map.svh"
`define CHK(nm, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pa_pin = 8'h3C;
  logic [7:0] pb_pin = 8'hC3, pf_pin, pa_dir, pb_dir, pb_out, pc_dir, pc_out;
  logic [7:0] pf_out, pf_oe, pf_pullup, pf_in_en;
  logic [4:0] pg_out, pg_oe, pg_pullup, pg_in_en;
  logic       wr = 1'b0, rd = 1'b0, test_data_src = 1'b0, legacy_mode = 1'b0;
  logic       xmem_ale = 1'b0, xmem_rd = 1'b0, xmem_wr = 1'b0;
  logic       ce = 1'b1;
  logic       tck, tms, tdi, tdo_line;
  int         err_count = 0, n_tests = 0;
  row_t       rows [8] = '{'{8'h1A, 8'h5A, 8'h5A}, '{8'h17, 8'hA5, 8'hA5},
    '{8'h14, 8'hFF, 8'hFF}, '{8'h18, 8'h81, 8'h81}, '{8'h15, 8'h7E, 8'h7E},
    '{8'h19, 8'h55, 8'h3C}, '{8'h16, 8'hAA, 8'hC3}, '{8'h40, 8'h77, 8'h00}};
  always #4 clock = ~clock;
  // released data-out line shows the inverse, never a stale level
  assign tdo_line = pf_oe[6] ? pf_out[6] : ~pf_out[6];
  assign pf_pin = {tdi, tdo_line, tms, tck, 4'hA};
  port_alt_function_override i_port_alt_function_override (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pa_pin(pa_pin),
    .pa_dir(pa_dir), .pb_pin(pb_pin), .pb_dir(pb_dir), .pb_out(pb_out),
    .pc_dir(pc_dir), .pc_out(pc_out), .pf_pin(pf_pin), .pf_out(pf_out),
    .pf_oe(pf_oe), .pf_pullup(pf_pullup), .pf_in_en(pf_in_en),
    .pg_out(pg_out), .pg_oe(pg_oe), .pg_pullup(pg_pullup),
    .pg_in_en(pg_in_en), .test_data_src(test_data_src),
    .xmem_ale(xmem_ale), .xmem_rd(xmem_rd), .xmem_wr(xmem_wr),
    .legacy_mode(legacy_mode));
  test_probe i_test_probe (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // pin outputs lag register writes by one more clock
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    repeat (5) @(posedge clock);
    #1;
    `CHK("pf_pullup", 8'hB0, pf_pullup);
    `CHK("pf_in_en", 8'h0F, pf_in_en);
    `CHK("pf_oe", 8'h00, pf_oe);
    `CHK("pa_dir", 8'h00, pa_dir);
    `CHK("pb_out", 8'h00, pb_out);
    @(posedge clock);
    sys_rst <= 1'b0;
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, d);
      `CHK("rdata", rows[i].e, d);
    end
    `CHK("dirs", 24'h5AA5FF, {pa_dir, pb_dir, pc_dir});
    `CHK("outs", 16'h817E, {pb_out, pc_out});
    $display("register test done");
    wr_reg(`ADDR_PORT_F_DIRECTION, 8'hFF);
    wr_reg(`ADDR_PORT_F_OUTPUT_DATA, 8'hFF);
    wait_n(3);
    `CHK("pf_oe", 8'h0F, pf_oe);
    `CHK("pf_pullup", 8'hB0, pf_pullup);
    `CHK("pf_in_en", 8'h0F, pf_in_en);
    `CHK("pf_out low", 4'hF, pf_out[3:0]);
    i_test_probe.step(1'b0);
    i_test_probe.step(1'b1);
    i_test_probe.step(1'b0);
    i_test_probe.step(1'b0);
    wait_n(3);
    `CHK("tdo drive", 1'b1, pf_oe[6]);
    @(posedge clock);
    test_data_src <= 1'b1;
    i_test_probe.step(1'b0);
    wait_n(2);
    `CHK("tdo value", 1'b1, pf_out[6]);
    i_test_probe.step(1'b1);
    wait_n(3);
    `CHK("tdo drive", 1'b0, pf_oe[6]);
    $display("test port done");
    wr_reg(`ADDR_PIN_CONTROL, 8'h00);
    wait_n(3);
    `CHK("pf_oe", 8'hFF, pf_oe);
    `CHK("pf_in_en", 8'hFF, pf_in_en);
    wr_reg(`ADDR_PORT_F_DIRECTION, 8'h00);
    wait_n(3);
    `CHK("pf_pullup", 8'hFF, pf_pullup);
    $display("release test done");
    wr_reg(`ADDR_PIN_CONTROL, 8'h02);
    wr_reg(`ADDR_PORT_G_DIRECTION, 8'h1F);
    wr_reg(`ADDR_PORT_G_OUTPUT_DATA, 8'h00);
    wait_n(3);
    `CHK("pg_oe", 5'h07, pg_oe);
    `CHK("pg_in_en", 5'h07, pg_in_en);
    @(posedge clock);
    xmem_ale <= 1'b1;
    xmem_wr <= 1'b1;
    wr_reg(`ADDR_PIN_CONTROL, 8'h04);
    wr_reg(`ADDR_PORT_G_DIRECTION, 8'h00);
    wr_reg(`ADDR_PORT_G_OUTPUT_DATA, 8'h1F);
    wait_n(3);
    `CHK("pg_oe", 5'h07, pg_oe);
    `CHK("pg_out", 3'b101, pg_out[2:0]);
    `CHK("pg_pullup", 5'h18, pg_pullup);
    $display("port g test done");
    @(posedge clock);
    legacy_mode <= 1'b1;
    wr_reg(`ADDR_PIN_CONTROL, 8'h00);
    wr_reg(`ADDR_PORT_G_DIRECTION, 8'h1F);
    wait_n(3);
    `CHK("pg_oe", 5'h00, pg_oe);
    `CHK("pg_pullup", 5'h00, pg_pullup);
    rd_reg(`ADDR_PIN_CONTROL, d);
    `CHK("legacy status", 1'b1, d[3]);
    @(posedge clock);
    xmem_ale <= 1'b0;
    xmem_rd <= 1'b1;
    xmem_wr <= 1'b0;
    wr_reg(`ADDR_PIN_CONTROL, 8'h07);
    wait_n(3);
    `CHK("pg_oe", 5'h07, pg_oe);
    `CHK("pg_out", 3'b010, pg_out[2:0]);
    @(posedge clock);
    sys_rst <= 1'b1;
    wait_n(1);
    `CHK("pullups in reset", 8'hB0, pf_pullup & 8'hB0);
    @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(`ADDR_PORT_A_DIRECTION, d);
    `CHK("pa_dir after reset", 8'h00, d);
    // write then read with no gap between the strobes
    @(posedge clock);
    addr <= `ADDR_PORT_A_DIRECTION;
    wdata <= 8'h69;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    `CHK("back to back read", 8'h69, rdata);
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(`ADDR_PORT_B_OUTPUT_DATA, 8'hEE);
    ce <= 1'b1;
    wait_n(1);
    `CHK("frozen write", 8'h00, pb_out);
    @(posedge clock);
    pa_pin <= 8'h96;
    pb_pin <= 8'h69;
    rd_reg(`ADDR_PORT_A_PIN_LEVELS, d);
    `CHK("pa pins", 8'h96, d);
    rd_reg(`ADDR_PORT_B_PIN_LEVELS, d);
    `CHK("pb pins", 8'h69, d);
    $display("legacy and reset test done");
    report_and_stop();
  end
endmodule // testbench
